// *** rtl/mode_sel.sv ***
// channel mode selection plus send-immediate / remote-wake strobe
// assumes inputs synchronous to clk_in; strobe already debounced
`timescale 1ns/10ps
`default_nettype none

module mode_sel
  import mode_sel_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
)
(
  input  wire logic         clk_in,
  input  wire logic         srst_in,
  input  wire logic         cfg_valid_in,
  input  wire logic [1:0]   cfg_mode_a_in,
  input  wire logic [1:0]   cfg_mode_b_in,
  input  wire logic         enumerated_in,
  input  wire bitmode_cmd_t bitmode_cmd_in,
  input  wire logic         flush_wake_strobe_n_in,
  input  wire logic         usb_suspended_in,
  input  wire logic         pulldown_enabled_in,
  input  wire logic         chan_b_used_in,
  input  wire pin_state_t   chan_b_pins_in,
  output var  chan_mode_t   mode_a_out,
  output var  chan_mode_t   mode_b_out,
  output logic              chan_b_mem_to_a_out,
  output var  pin_state_t   chan_b_pins_out,
  output logic              transfer_flag_out,
  output logic              flush_out,
  output logic              wake_out
);

  // ******************************
  // parameter check
  // ******************************
  if (WAKE_CYCLES <= FLUSH_CYCLES)
  begin : g_bad
    $error("wake pulse must exceed flush pulse");
  end

  if (WAKE_CYCLES > 32'h3FFF_FFFF)
  begin : g_too_long
    $error("wake pulse count out of range");
  end

  localparam int CW = $clog2(WAKE_CYCLES + 1);

  chan_mode_t mode_a_r;
  chan_mode_t mode_b_r;
  chan_mode_t mode_a_nxt;
  chan_mode_t mode_b_nxt;
  chan_mode_t cfg_a_mode;
  chan_mode_t cfg_b_mode;
  logic       cfg_loaded_r;
  logic       mem_to_a_r;
  pin_state_t pins_r;
  logic       strobe_d_r;
  logic       low_r;
  logic [CW-1:0] low_cnt_r;
  logic       flag_r;
  logic       flush_r;
  logic       wake_r;
  logic       armed_r;
  logic       armed_ok;
  logic       cfg_take;
  logic       b_live;
  pin_state_t pins_live;
  pin_state_t pins_nxt;
  logic       low_nxt;
  logic       armed_nxt;
  logic [CW-1:0] low_cnt_nxt;
  logic       flush_nxt;
  logic       wake_nxt;

  // ******************************
  // configuration memory decode
  // ******************************
  function automatic chan_mode_t cfg_decode(input logic [1:0] c);
    chan_mode_t m;
    m = MODE_ASYNC_SERIAL;
    if (c == CFG_ASYNC_FIFO)
      m = MODE_ASYNC_FIFO;
    else if (c == CFG_CPU_FIFO)
      m = MODE_CPU_FIFO;
    else if (c == CFG_FAST_SERIAL)
      m = MODE_FAST_SERIAL;
    return m;
  endfunction

  assign cfg_a_mode = cfg_decode(cfg_mode_a_in);
  assign cfg_b_mode = cfg_decode(cfg_mode_b_in);

  // ******************************
  // bit-mode command decode
  // ******************************
  function automatic chan_mode_t bm_decode(input chan_mode_t cur,
                                           input chan_mode_t base,
                                           input logic [7:0] v);
    chan_mode_t m;
    m = cur;
    if (v == BM_RESET)
      m = base;
    else if (v == BM_ASYNC_BB)
      m = MODE_ASYNC_BITBANG;
    else if (v == BM_SYNC_BB)
      m = MODE_SYNC_BITBANG;
    else if (v == BM_CMD_ENGINE)
      m = MODE_CMD_ENGINE;
    else if (v == BM_HOST_BUS_EMU)
      m = MODE_HOST_BUS_EMU;
    return m;
  endfunction

  chan_mode_t base_a_r;
  chan_mode_t base_b_r;
  wire sync_req = bitmode_cmd_in.valid && !bitmode_cmd_in.chan &&
                  bitmode_cmd_in.value == BM_SYNC_FIFO;
  wire sync_ok  = mode_a_r == MODE_ASYNC_FIFO &&
                  mode_b_r == MODE_ASYNC_FIFO;
  wire cmd_a    = bitmode_cmd_in.valid && !bitmode_cmd_in.chan &&
                  enumerated_in && cfg_loaded_r;
  wire cmd_b    = bitmode_cmd_in.valid && bitmode_cmd_in.chan &&
                  enumerated_in && cfg_loaded_r &&
                  mode_b_r != MODE_UNAVAILABLE;

  always_comb
  begin
    mode_a_nxt = mode_a_r;
    mode_b_nxt = mode_b_r;
    if (!cfg_loaded_r && cfg_valid_in)
    begin
      mode_a_nxt = cfg_a_mode;
      mode_b_nxt = cfg_b_mode;
    end
    else if (cmd_a && sync_req && sync_ok)
    begin
      mode_a_nxt = MODE_SYNC_FIFO;
      mode_b_nxt = MODE_UNAVAILABLE;
    end
    else if (cmd_a && !sync_req)
      mode_a_nxt = bm_decode(mode_a_r, base_a_r, bitmode_cmd_in.value);
    else if (cmd_b)
      mode_b_nxt = bm_decode(mode_b_r, base_b_r, bitmode_cmd_in.value);
  end

  wire enter_sync = mode_a_nxt == MODE_SYNC_FIFO &&
                    mode_a_r != MODE_SYNC_FIFO;

  assign cfg_take = !cfg_loaded_r && cfg_valid_in;
  assign b_live   = mode_b_r != MODE_UNAVAILABLE;

  // ******************************
  // channel mode registers
  // ******************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mode_a_r <= MODE_ASYNC_SERIAL;
      mode_b_r <= MODE_ASYNC_SERIAL;
    end
    else
    begin
      mode_a_r <= mode_a_nxt;
      mode_b_r <= mode_b_nxt;
    end
  end

  // ******************************
  // configured base modes
  // ******************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      base_a_r     <= MODE_ASYNC_SERIAL;
      base_b_r     <= MODE_ASYNC_SERIAL;
      cfg_loaded_r <= 1'b0;
    end
    else if (cfg_take)
    begin
      base_a_r     <= cfg_a_mode;
      base_b_r     <= cfg_b_mode;
      cfg_loaded_r <= 1'b1;
    end
  end

  // ******************************
  // channel b memory and pins
  // ******************************
  assign pins_live = chan_b_used_in ? chan_b_pins_in : PIN_DEFAULT;
  assign pins_nxt  = (enter_sync || b_live) ? pins_live : pins_r;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      mem_to_a_r <= 1'b0;
      pins_r     <= PIN_DEFAULT;
    end
    else
    begin
      mem_to_a_r <= mem_to_a_r || enter_sync;
      pins_r     <= pins_nxt;
    end
  end

  // ******************************
  // flush / wake strobe
  // ******************************
  function automatic logic strobe_mode(input chan_mode_t m);
    return m == MODE_ASYNC_FIFO || m == MODE_SYNC_FIFO ||
           m == MODE_CPU_FIFO || m == MODE_ASYNC_BITBANG ||
           m == MODE_SYNC_BITBANG;
  endfunction

  assign armed_ok = strobe_mode(mode_a_r);
  wire fall = strobe_d_r && !flush_wake_strobe_n_in;
  wire rise = !strobe_d_r && flush_wake_strobe_n_in;
  wire long_enough = low_cnt_r >= CW'(WAKE_CYCLES);
  wire wake_hit = low_r && armed_r && !long_enough &&
                  low_cnt_r == CW'(WAKE_CYCLES - 1);

  // ******************************
  // strobe edge and transfer flag
  // ******************************
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      strobe_d_r <= 1'b1;
      flag_r     <= 1'b0;
    end
    else
    begin
      strobe_d_r <= flush_wake_strobe_n_in;
      flag_r     <= fall && armed_ok;
    end
  end

  // ******************************
  // low pulse length
  // ******************************
  assign low_nxt     = fall || (low_r && !rise);
  assign armed_nxt   = fall ? armed_ok : armed_r && !(rise && low_r);
  assign low_cnt_nxt = fall ? CW'(1)
                     : (low_r && !rise && !long_enough) ? low_cnt_r + CW'(1)
                     : low_cnt_r;

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      low_r     <= 1'b0;
      low_cnt_r <= '0;
      armed_r   <= 1'b0;
    end
    else
    begin
      low_r     <= low_nxt;
      low_cnt_r <= low_cnt_nxt;
      armed_r   <= armed_nxt;
    end
  end

  // ******************************
  // flush and wake pulses
  // ******************************
  assign wake_nxt  = wake_hit && usb_suspended_in &&
                     !pulldown_enabled_in;
  assign flush_nxt = rise && low_r && armed_r &&
                     low_cnt_r >= CW'(FLUSH_CYCLES) && !long_enough &&
                     !(usb_suspended_in &&
                       low_cnt_r >= CW'(WAKE_CYCLES - 1));

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      flush_r <= 1'b0;
      wake_r  <= 1'b0;
    end
    else
    begin
      flush_r <= flush_nxt;
      wake_r  <= wake_nxt;
    end
  end

  assign mode_a_out          = mode_a_r;
  assign mode_b_out          = mode_b_r;
  assign chan_b_mem_to_a_out = mem_to_a_r;
  assign chan_b_pins_out     = pins_r;
  assign transfer_flag_out   = flag_r;
  assign flush_out           = flush_r;
  assign wake_out            = wake_r;

endmodule

`default_nettype wire

// *** shared/mode_sel_pkg.sv ***
// constants, modes and carriers for channel mode selection and flush/wake
// assumes a single 200 MHz clock
package mode_sel_pkg;

  // ******************************
  // channel modes
  // ******************************
  typedef enum logic [3:0]
  {
    MODE_ASYNC_SERIAL,
    MODE_ASYNC_FIFO,
    MODE_CPU_FIFO,
    MODE_FAST_SERIAL,
    MODE_SYNC_FIFO,
    MODE_ASYNC_BITBANG,
    MODE_SYNC_BITBANG,
    MODE_CMD_ENGINE,
    MODE_HOST_BUS_EMU,
    MODE_UNAVAILABLE
  } chan_mode_t;

  // ******************************
  // configuration memory encoding
  // ******************************
  localparam logic [1:0] CFG_ASYNC_SERIAL = 2'h0;
  localparam logic [1:0] CFG_ASYNC_FIFO   = 2'h1;
  localparam logic [1:0] CFG_CPU_FIFO     = 2'h2;
  localparam logic [1:0] CFG_FAST_SERIAL  = 2'h3;

  // ******************************
  // bit-mode command values
  // ******************************
  localparam logic [7:0] BM_RESET        = 8'h00;
  localparam logic [7:0] BM_ASYNC_BB     = 8'h01;
  localparam logic [7:0] BM_CMD_ENGINE   = 8'h02;
  localparam logic [7:0] BM_SYNC_BB      = 8'h04;
  localparam logic [7:0] BM_HOST_BUS_EMU = 8'h08;
  localparam logic [7:0] BM_SYNC_FIFO    = 8'h40;

  // ******************************
  // timing
  // ******************************
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int FLUSH_PULSE_NS  = 250;
  localparam int WAKE_PULSE_MS   = 20;
  localparam int FLUSH_CYCLES    =
    (FLUSH_PULSE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int WAKE_CYCLES_DEF =
    WAKE_PULSE_MS * (1000000000 / CLK_PERIOD_PS);

  // ******************************
  // channel b idle pin state
  // ******************************
  typedef struct packed
  {
    logic [7:0] data_out;
    logic [7:0] data_oe_n;
    logic       space_available_flag_n;
    logic       data_present_flag_n;
    logic       strobes_are_inputs;
  } pin_state_t;

  localparam pin_state_t PIN_DEFAULT =
    '{8'h00, 8'hFF, 1'b0, 1'b1, 1'b1};

  typedef struct packed
  {
    logic       valid;
    logic       chan;
    logic [7:0] value;
  } bitmode_cmd_t;

endpackage

// *** verification/mode_sel_properties.sv ***
// concurrent checks on the mode select and flush/wake ports
// assumes a bind to mode_sel and a single clock domain
`timescale 1ns/10ps
`default_nettype none
module mode_sel_properties
  import mode_sel_pkg::*;
#(
  parameter int WAKE_CYCLES = WAKE_CYCLES_DEF
)
(
  input wire logic       clk_in,
  input wire logic       srst_in,
  input wire logic       flush_wake_strobe_n_in,
  input wire logic       usb_suspended_in,
  input wire logic       pulldown_enabled_in,
  input wire logic       chan_b_used_in,
  input wire chan_mode_t mode_a_out,
  input wire chan_mode_t mode_b_out,
  input wire logic       chan_b_mem_to_a_out,
  input wire pin_state_t chan_b_pins_out,
  input wire logic       transfer_flag_out,
  input wire logic       flush_out,
  input wire logic       wake_out
);
  // ******************************
  // helpers and properties
  // ******************************
  logic        ok_a;
  int unsigned low_r;
  assign ok_a = mode_a_out inside {MODE_ASYNC_FIFO, MODE_CPU_FIFO,
    MODE_SYNC_FIFO, MODE_ASYNC_BITBANG, MODE_SYNC_BITBANG};
  always_ff @(posedge clk_in)
    low_r <= (srst_in || flush_wake_strobe_n_in) ? 0 : low_r + 1;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  a_reset_serial: assert property ($fell(srst_in) |->
    mode_a_out == MODE_ASYNC_SERIAL && mode_b_out == MODE_ASYNC_SERIAL)
    else $error("modes not serial after reset");
  a_fall_flags: assert property ($fell(flush_wake_strobe_n_in) &&
    ok_a |-> ##[1:2] transfer_flag_out)
    else $error("no transfer flag after strobe fall");
  a_wake_blocked: assert property ((pulldown_enabled_in ||
    !usb_suspended_in) [*3] |-> !wake_out)
    else $error("wake while blocked");
  a_flush_release: assert property ($rose(flush_wake_strobe_n_in) &&
    ok_a && low_r >= FLUSH_CYCLES + 2 && low_r < WAKE_CYCLES - 2
    |-> ##[1:3] flush_out) else $error("short pulse gave no flush");
  a_wake_hold: assert property (wake_out |-> !flush_wake_strobe_n_in &&
    low_r inside {[WAKE_CYCLES - 3 : WAKE_CYCLES + 1]})
    else $error("wake at wrong pulse length");
  a_mem_modes: assert property ($rose(chan_b_mem_to_a_out) |->
    mode_a_out == MODE_SYNC_FIFO && mode_b_out == MODE_UNAVAILABLE)
    else $error("memory moved without sync fifo");
  a_pins_frozen: assert property (chan_b_mem_to_a_out |=>
    $stable(chan_b_pins_out)) else $error("channel b pins moved");
  a_unused_default: assert property (!chan_b_used_in &&
    !chan_b_mem_to_a_out |=> chan_b_pins_out == PIN_DEFAULT)
    else $error("unused channel b pins not default");
endmodule
bind mode_sel mode_sel_properties #(.WAKE_CYCLES(WAKE_CYCLES)) chk (
  .clk_in, .srst_in, .flush_wake_strobe_n_in, .usb_suspended_in,
  .pulldown_enabled_in, .chan_b_used_in, .mode_a_out, .mode_b_out,
  .chan_b_mem_to_a_out, .chan_b_pins_out, .transfer_flag_out, .flush_out,
  .wake_out);
`default_nettype wire

// *** verification/mode_sel_tb.sv ***
// bench for mode_sel: mode model, strobe pulses, channel b pins
// assumes strobe_peer drives the strobe and a 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module mode_sel_tb
  import mode_sel_pkg::*;
;
  // ******************************
  // stimulus, model and checks
  // ******************************
  logic clk = 0, srst = 1, cfg_v = 0, en = 1, susp = 0, pd = 0, used = 0;
  logic mem, flag, flush, wake, em = 0, loaded = 0;
  bitmode_cmd_t cmd = '0;
  pin_state_t pins = '0, frz, pins_o;
  wire logic strobe_n;
  chan_mode_t mode_a, mode_b, ea, eb;
  int error_cnt = 0, check_count = 0;
  integer nf = 0, nfl = 0, nw = 0;
  logic [31:0] rnd;
  logic [7:0] bv [5] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h00};
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (!srst)
    begin
      nf = nf + flag;
      nfl = nfl + flush;
      nw = nw + wake;
    end
  end
  mode_sel #(.WAKE_CYCLES(200)) dut (.clk_in(clk), .srst_in(srst),
    .cfg_valid_in(cfg_v), .cfg_mode_a_in(2'h1), .cfg_mode_b_in(2'h1),
    .enumerated_in(en), .bitmode_cmd_in(cmd),
    .flush_wake_strobe_n_in(strobe_n), .usb_suspended_in(susp),
    .pulldown_enabled_in(pd), .chan_b_used_in(used), .chan_b_pins_in(pins),
    .mode_a_out(mode_a), .mode_b_out(mode_b), .chan_b_mem_to_a_out(mem),
    .chan_b_pins_out(pins_o), .transfer_flag_out(flag), .flush_out(flush),
    .wake_out(wake));
  strobe_peer peer (.clk_in(clk), .strobe_n_out(strobe_n));
  task automatic send(input logic ch, input logic [7:0] v);
    chan_mode_t m;
    @(negedge clk);
    cmd = '{1'b1, ch, v};
    @(negedge clk);
    cmd.valid = 1'b0;
    m = ch ? eb : ea;
    if (loaded && en && m != MODE_UNAVAILABLE)
    begin
      case (v)
        8'h00: m = MODE_ASYNC_FIFO;
        8'h01: m = MODE_ASYNC_BITBANG;
        8'h02: m = MODE_CMD_ENGINE;
        8'h04: m = MODE_SYNC_BITBANG;
        8'h08: m = MODE_HOST_BUS_EMU;
        8'h40:
          if (!ch && ea == MODE_ASYNC_FIFO && eb == MODE_ASYNC_FIFO)
          begin
            em = 1'b1;
            m  = MODE_SYNC_FIFO;
            eb = MODE_UNAVAILABLE;
          end
        default: ;
      endcase
      if (ch)
        eb = m;
      else
        ea = m;
    end
    @(negedge clk);
    `CHK("mode_a", ea, mode_a)
    `CHK("mode_b", eb, mode_b)
    `CHK("mem_to_a", em, mem)
  endtask
  task automatic strobe(input int n, input int xf, xfl, xw);
    integer f0, l0, w0;
    f0 = nf;
    l0 = nfl;
    w0 = nw;
    peer.pulse(n);
    repeat (6) @(negedge clk);
    `CHK("flag", xf, nf - f0)
    `CHK("flush", xfl, nfl - l0)
    `CHK("wake", xw, nw - w0)
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    complete_run;
  end
  initial
  begin
    void'($urandom(86727));
    ea = MODE_ASYNC_SERIAL;
    eb = MODE_ASYNC_SERIAL;
    repeat (3) @(negedge clk);
    srst = 0;
    @(negedge clk);
    `CHK("pins", PIN_DEFAULT, pins_o)
    send(1'b0, BM_ASYNC_BB);
    strobe(60, 0, 0, 0);
    cfg_v = 1;
    @(negedge clk);
    cfg_v = 0;
    loaded = 1;
    ea = MODE_ASYNC_FIFO;
    eb = MODE_ASYNC_FIFO;
    `CHK("mode_a", ea, mode_a)
    `CHK("mode_b", eb, mode_b)
    send(1'b0, BM_RESET);
    foreach (bv[i])
    begin
      send(1'b0, bv[i]);
      send(1'b1, bv[i]);
    end
    en = 0;
    send(1'b0, BM_CMD_ENGINE);
    en = 1;
    send(1'b1, BM_ASYNC_BB);
    send(1'b0, BM_SYNC_FIFO);
    send(1'b1, BM_RESET);
    strobe(60, 1, 1, 0);
    strobe(10, 1, 0, 0);
    susp = 1;
    pd = 1;
    strobe(210, 1, 0, 0);
    pd = 0;
    strobe(210, 1, 0, 1);
    susp = 0;
    strobe(210, 1, 0, 0);
    used = 1;
    rnd = $urandom;
    pins = rnd[18:0];
    pins.data_oe_n = 8'hFF;
    frz = pins;
    repeat (2) @(negedge clk);
    `CHK("pins", frz, pins_o)
    send(1'b0, BM_SYNC_FIFO);
    repeat (4)
    begin
      rnd = $urandom;
      pins = rnd[18:0];
      @(negedge clk);
      `CHK("pins", frz, pins_o)
    end
    send(1'b1, BM_ASYNC_BB);
    strobe(60, 1, 1, 0);
    complete_run;
  end
endmodule
`default_nettype wire

// *** verification/strobe_peer.sv ***
// peripheral logic that drives the flush/wake strobe
// assumes the bench clock; changes only at falling edges
`timescale 1ns/10ps
`default_nettype none
module strobe_peer
(
  input  wire logic clk_in,
  output var  logic strobe_n_out
);
  // ******************************
  // low pulse of n cycles, starting at the next falling edge
  // ******************************
  initial strobe_n_out = 1'b1;
  task automatic pulse(input int n);
    @(negedge clk_in);
    strobe_n_out = 1'b0;
    repeat (n) @(negedge clk_in);
    strobe_n_out = 1'b1;
  endtask
endmodule
`default_nettype wire
